// *** urb_pkg.sv ***
// Shared constants and types for the serial receive block.
// Assumes one system clock and a 32-bit AHB-Lite register bus.
package urb_pkg;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] URB_OFF_DATA    = 8'h00;
	localparam logic [7:0] URB_OFF_STATUS  = 8'h04;
	localparam logic [7:0] URB_OFF_CONTROL = 8'h08;
	localparam logic [7:0] URB_OFF_FORMAT  = 8'h0C;
	localparam logic [7:0] URB_OFF_BAUD    = 8'h10;

	// Field positions in serial_status_register.
	localparam int URB_STS_RXC        = 7;
	localparam int URB_STS_FRAME_ERR  = 4;
	localparam int URB_STS_OVERRUN    = 3;
	localparam int URB_STS_PARITY_ERR = 2;
	localparam int URB_STS_DOUBLE     = 1;

	// Field positions in serial_control_register.
	localparam int URB_CTL_IRQ_EN = 7;
	localparam int URB_CTL_RX_EN  = 4;
	localparam int URB_CTL_NINTH  = 1;

	// Field positions in serial_format_register.
	localparam int URB_FMT_PEN  = 5;
	localparam int URB_FMT_PODD = 4;
	localparam int URB_FMT_SBS  = 3;
	localparam int URB_FMT_CSZ  = 0;

	// Values after reset.
	localparam logic [2:0]  URB_CSZ_RST  = 3'h3;
	localparam logic [11:0] URB_BAUD_RST = 12'h000;

	// Character size code for nine data bits.
	localparam logic [2:0] URB_CSZ_NINE = 3'h7;

	// Samples per bit in normal and in double-speed mode.
	localparam logic [4:0] URB_SPB_NORMAL = 5'h10;
	localparam logic [4:0] URB_SPB_DOUBLE = 5'h08;

	// Receiver recovery states.
	typedef enum logic [2:0] {
		URB_IDLE   = 3'b000,
		URB_START  = 3'b001,
		URB_DATA   = 3'b010,
		URB_PARITY = 3'b011,
		URB_STOP   = 3'b100
	} urb_state_e;

	// One received character with its own status flags.
	typedef struct packed {
		logic [8:0] data;
		logic       frame_err;
		logic       overrun;
		logic       parity_err;
	} urb_entry_s;

endpackage

// *** urb_sampler.sv ***
// Pin synchroniser and oversampling tick divider for the receiver.
// Assumes the receive pin is asynchronous to hclk.
`timescale 1ns/1ps
module urb_sampler (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Serial pin and divider setting.
	input  wire logic        serial_rx_pin,
	input  wire logic [11:0] baud_div,
	// Sample enable and clean line level.
	output logic             sample_tick,
	output logic             rx_level
);
	import urb_pkg::*;

	typedef struct packed {
		logic [1:0]  sync;
		logic [11:0] cnt;
		logic        tick;
	} urb_smp_s;

	urb_smp_s s;
	urb_smp_s next_s;

	// Two-stage synchroniser and a divider that pulses once per baud_div+1 clocks.
	always_comb begin
		next_s = s;
		next_s.sync = {s.sync[0], serial_rx_pin};
		next_s.tick = 1'b0;
		if (s.cnt >= baud_div) begin
			next_s.cnt = 12'h000;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 12'h001;
		end
	end

	// State register; the line idles high.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '{sync: 2'h3, cnt: 12'h000, tick: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign sample_tick = s.tick;
	assign rx_level = s.sync[1];
endmodule

// *** urb_rx.sv ***
// Serial receiver with a two-entry buffer and an AHB-Lite register slave.
// Assumes one 100 MHz clock, single-word bus transfers and one bus master.
//
// How it works
// - Receive-complete flag is high exactly while the buffer holds unread characters.
// - Clearing receiver enable empties the buffer, so receive-complete drops.
// - Interrupt request follows flag AND its enable AND the global enable.
// - Error flags live in each buffer entry; data read advances to next entry.
// - Software writes to error flag bits are ignored.
// - Error flags never raise an interrupt request.
// - Frame error shows when the first stop bit was voted low.
// - Only the first stop bit is checked; stop count setting is ignored.
// - Overrun when buffer full, shift register waiting and a new start arrives.
// - Overrun set means frames were lost between two data reads; here it stays set when a read frees room before the new frame ends.
// - Overrun clears when a frame moves from shift register into the buffer.
// - Parity checked only when parity enable set; other bit picks odd.
// - Checker compares data parity with received bit; result stored per entry.
// - Parity error shows only for failed checks made while checking was on.
// - Parity error reads zero while checking is disabled.
// - Disabling the receiver abandons any frame in progress at once.
// - Pin override released while the receiver is disabled.
// - Sampling locks to each frame and every bit is filtered.
// - Oversampling is sixteen per bit, or eight in double speed.
// - Start bit voted on samples 8-10 or 4-6; mostly high rejects it.
// - Every later bit is the majority of its three centre samples.
// - A low voted stop bit records a frame error.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module urb_rx (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Serial line.
	input  wire logic        serial_rx_pin,
	output logic             rx_pin_override,
	// Interrupt request.
	input  wire logic        global_irq_enable,
	output logic             rx_complete_irq
);
	import urb_pkg::*;

	// Register map, one word per register, unused bits read as zero.
	// Data at offset 0x00 returns the oldest unread character and pops it.
	// Status at 0x04 shows receive-complete and the head entry's error flags.
	// Only the double-speed bit of the status word can be written.
	// Control at 0x08 holds the interrupt enable and the receiver enable.
	// Control also shows the ninth bit of the head entry.
	// Format at 0x0C holds parity enable, odd parity, stop-bit count and size.
	// Baud at 0x10 holds the divisor; one sample tick every divisor+1 clocks.
	// The buffer is two entries deep; a third character waits in the hold.
	// A character that ends while the hold is still full is lost.
	// A lost character sets a pending overrun that rides on the next entry.
	// That pending overrun clears once the entry moves into the buffer.

	typedef struct packed {
		// Bus side.
		logic             dp_v;
		logic             dp_wr;
		logic [7:0]       dp_addr;
		logic             rdy;
		logic [31:0]      rdata;
		// Settings.
		logic             receiver_enable;
		logic             rx_complete_irq_enable;
		logic             double_speed_select;
		logic             parity_enable_bit;
		logic             parity_odd_select;
		logic             stop_bit_count_select;
		logic [2:0]       csz;
		logic [11:0]      baud;
		// Recovery.
		urb_state_e       st;
		logic [4:0]       cnt;
		logic [2:0]       vote;
		logic [3:0]       nbit;
		logic [8:0]       shreg;
		logic             par;
		// Shift register hold and buffer.
		logic             hold_v;
		urb_entry_s       hold;
		logic             overrun_pend;
		urb_entry_s [1:0] fifo;
		logic             rdp;
		logic [1:0]       count;
		// Pin outputs.
		logic             irq;
		logic             ovr;
	} urb_rx_s;

	urb_rx_s s;
	urb_rx_s next_s;

	logic sample_tick;
	logic rx_level;

	// Synchronised line and sample enable.
	urb_sampler u_sampler (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.serial_rx_pin (serial_rx_pin),
		.baud_div      (s.baud),
		.sample_tick   (sample_tick),
		.rx_level      (rx_level)
	);

	// Views of the state used by the next-state logic.
	logic       rxc;
	urb_entry_s head;
	logic [4:0] spb;
	logic [4:0] v_first;
	logic [4:0] v_last;
	logic [4:0] smp;
	logic [3:0] nbits;
	logic [2:0] v_now;
	logic       maj;
	logic [8:0] rx_data;
	logic       exp_par;
	logic       wr_idx;

	// Derived views of the current state.
	always_comb begin
		rxc = (s.count != 2'h0);
		head = s.fifo[s.rdp];
		spb = s.double_speed_select ? URB_SPB_DOUBLE : URB_SPB_NORMAL;
		v_first = spb >> 1;
		v_last = v_first + 5'h02;
		smp = (s.cnt == spb) ? 5'h01 : s.cnt + 5'h01;
		if (s.csz == URB_CSZ_NINE) begin
			nbits = 4'h9;
		end else if (s.csz[2]) begin
			nbits = 4'h8;
		end else begin
			nbits = {2'b00, s.csz[1:0]} + 4'h5;
		end
		v_now = {s.vote[1:0], rx_level};
		maj = (v_now[0] & v_now[1]) | (v_now[0] & v_now[2]) | (v_now[1] & v_now[2]);
		rx_data = s.shreg >> (4'h9 - nbits);
		exp_par = (^rx_data) ^ s.parity_odd_select;
	end

	// Next state: bus access, buffer movement, frame recovery, disable.
	always_comb begin
		next_s = s;
		wr_idx = 1'b0;

		// Write data phase; error flag bits are never written.
		if (s.dp_v && s.dp_wr) begin
			next_s.dp_v = 1'b0;
			case (s.dp_addr)
				URB_OFF_STATUS: begin
					next_s.double_speed_select = hwdata[URB_STS_DOUBLE];
				end
				URB_OFF_CONTROL: begin
					next_s.rx_complete_irq_enable = hwdata[URB_CTL_IRQ_EN];
					next_s.receiver_enable = hwdata[URB_CTL_RX_EN];
				end
				URB_OFF_FORMAT: begin
					next_s.parity_enable_bit = hwdata[URB_FMT_PEN];
					next_s.parity_odd_select = hwdata[URB_FMT_PODD];
					next_s.stop_bit_count_select = hwdata[URB_FMT_SBS];
					next_s.csz = hwdata[URB_FMT_CSZ +: 3];
				end
				URB_OFF_BAUD: begin
					next_s.baud = hwdata[11:0];
				end
				default: begin
					next_s.baud = s.baud;
				end
			endcase
		end

		// Read data phase: one wait cycle, then data with hreadyout high.
		if (s.dp_v && !s.dp_wr) begin
			next_s.dp_v = 1'b0;
			next_s.rdy = 1'b1;
			next_s.rdata = 32'h0000_0000;
			case (s.dp_addr)
				URB_OFF_DATA: begin
					// An empty buffer is left untouched and the read returns zero.
					if (rxc) begin
						next_s.rdata[7:0] = head.data[7:0];
						next_s.rdp = ~s.rdp;
						next_s.count = s.count - 2'h1;
					end
				end
				URB_OFF_STATUS: begin
					next_s.rdata[URB_STS_RXC] = rxc;
					next_s.rdata[URB_STS_FRAME_ERR] = rxc & head.frame_err;
					next_s.rdata[URB_STS_OVERRUN] = rxc & head.overrun;
					next_s.rdata[URB_STS_PARITY_ERR] = rxc & head.parity_err & s.parity_enable_bit;
					next_s.rdata[URB_STS_DOUBLE] = s.double_speed_select;
				end
				URB_OFF_CONTROL: begin
					next_s.rdata[URB_CTL_IRQ_EN] = s.rx_complete_irq_enable;
					next_s.rdata[URB_CTL_RX_EN] = s.receiver_enable;
					next_s.rdata[URB_CTL_NINTH] = rxc & head.data[8];
				end
				URB_OFF_FORMAT: begin
					next_s.rdata[URB_FMT_PEN] = s.parity_enable_bit;
					next_s.rdata[URB_FMT_PODD] = s.parity_odd_select;
					next_s.rdata[URB_FMT_SBS] = s.stop_bit_count_select;
					next_s.rdata[URB_FMT_CSZ +: 3] = s.csz;
				end
				URB_OFF_BAUD: begin
					next_s.rdata[11:0] = s.baud;
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Address phase; a read drops hreadyout for one cycle.
		// Addresses above the register page decode as unmapped and read zero.
		if (hsel && htrans[1] && hready) begin
			next_s.dp_v = 1'b1;
			next_s.dp_wr = hwrite;
			next_s.dp_addr = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
			next_s.rdy = hwrite;
		end

		// Move a finished frame from the shift register into the buffer.
		if (next_s.hold_v && next_s.count != 2'h2) begin
			wr_idx = next_s.rdp ^ next_s.count[0];
			next_s.fifo[wr_idx] = s.hold;
			next_s.fifo[wr_idx].overrun = s.overrun_pend;
			next_s.overrun_pend = 1'b0;
			next_s.hold_v = 1'b0;
			next_s.count = next_s.count + 2'h1;
		end

		// Frame recovery on each oversampling tick.
		if (sample_tick && s.receiver_enable) begin
			if (s.st == URB_IDLE) begin
				if (!rx_level) begin
					next_s.st = URB_START;
					next_s.cnt = 5'h01;
					next_s.vote = 3'h0;
				end
			end else begin
				next_s.cnt = smp;
				if (smp >= v_first && smp <= v_last) begin
					next_s.vote = v_now;
				end
				if (smp == v_last) begin
					case (s.st)
						URB_START: begin
							if (maj) begin
								next_s.st = URB_IDLE;
							end else begin
								next_s.st = URB_DATA;
								next_s.nbit = 4'h0;
								next_s.shreg = 9'h000;
								if (s.hold_v && s.count == 2'h2) begin
									next_s.overrun_pend = 1'b1;
								end
							end
						end
						URB_DATA: begin
							next_s.shreg = {maj, s.shreg[8:1]};
							next_s.nbit = s.nbit + 4'h1;
							if (s.nbit + 4'h1 == nbits) begin
								next_s.st = s.parity_enable_bit ? URB_PARITY : URB_STOP;
							end
						end
						URB_PARITY: begin
							next_s.par = maj;
							next_s.st = URB_STOP;
						end
						URB_STOP: begin
							// Only the first stop bit is examined; a second is idle line.
							next_s.st = URB_IDLE;
							// The hold may drain into the buffer this cycle, so its next value decides.
							if (next_s.hold_v) begin
								next_s.overrun_pend = 1'b1;
							end else begin
								next_s.hold_v = 1'b1;
								next_s.hold.data = rx_data;
								next_s.hold.frame_err = ~maj;
								next_s.hold.overrun = 1'b0;
								next_s.hold.parity_err = s.parity_enable_bit & (s.par != exp_par);
							end
						end
						default: begin
							next_s.st = URB_IDLE;
						end
					endcase
				end
			end
		end

		// A disabled receiver drops its frame and empties the buffer at once.
		if (!s.receiver_enable) begin
			// The stored characters stay in the array but are no longer counted.
			next_s.st = URB_IDLE;
			next_s.hold_v = 1'b0;
			next_s.overrun_pend = 1'b0;
			next_s.count = 2'h0;
			next_s.rdp = 1'b0;
		end

		// Only receive-complete can request an interrupt.
		next_s.irq = (next_s.count != 2'h0) & next_s.rx_complete_irq_enable & global_irq_enable;
		next_s.ovr = next_s.receiver_enable;
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.rdy <= 1'b1;
			s.csz <= URB_CSZ_RST;
			s.baud <= URB_BAUD_RST;
			s.st <= URB_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register, except hresp, which is tied low.
	assign hreadyout = s.rdy;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign rx_complete_irq = s.irq;
	assign rx_pin_override = s.ovr;
endmodule

// *** urb_rx_props.sv ***
// Bus handshake and interrupt checks for the serial receive block.
// Assumes it is bound to urb_rx and sees only that module's ports.
`timescale 1ns/1ps
module urb_rx_props (
	// Clock and reset.
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus.
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Serial side and interrupt.
	input wire logic        rx_pin_override,
	input wire logic        global_irq_enable,
	input wire logic        rx_complete_irq
);
	logic rd_req;
	logic wr_req;
	// Transfers accepted at this edge.
	assign rd_req = hsel && htrans[1] && hready && !hwrite;
	assign wr_req = hsel && htrans[1] && hready && hwrite;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// A read stalls exactly one cycle and then completes.
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_read_one_wait: assert property (rd_req |=> s_one_wait) else $error("read wait wrong");
	a_write_no_wait: assert property (wr_req |=> hreadyout) else $error("write stalled");
	a_wait_has_cause: assert property (!hreadyout |-> $past(rd_req)) else $error("stall without read");
	a_rdata_holds: assert property ($changed(hrdata) |-> $rose(hreadyout)) else $error("read data moved");
	a_irq_global_off: assert property (!global_irq_enable |=> !rx_complete_irq) else $error("irq while masked");
	a_irq_needs_rx: assert property (rx_complete_irq |-> $past(rx_pin_override)) else $error("irq while off");
	a_flush_quiet: assert property ($fell(rx_pin_override) |=> !rx_complete_irq [*3]) else $error("no flush");
endmodule
bind urb_rx urb_rx_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_pin_override(rx_pin_override),
	.global_irq_enable(global_irq_enable), .rx_complete_irq(rx_complete_irq));

// *** urb_tx_model.sv ***
// Remote transmitter that drives the serial receive line.
// Assumes bit times are counted in hclk cycles; the line idles high.
`timescale 1ns/1ps
module urb_tx_model (
	// Clock.
	input  wire logic hclk,
	// Serial line.
	output logic      line
);
	// The line rests at its idle high level between frames.
	initial line = 1'b1;
	// Sends start bit, data LSB first, optional parity and one stop bit.
	task automatic send(input logic [8:0] d, input int n, input int bt, input logic pen, input logic par,
		input logic stp);
		line <= 1'b0;
		repeat (bt) @(posedge hclk);
		for (int i = 0; i < n; i++) begin
			line <= d[i];
			repeat (bt) @(posedge hclk);
		end
		if (pen) begin
			line <= par;
			repeat (bt) @(posedge hclk);
		end
		line <= stp;
		repeat (bt) @(posedge hclk);
		line <= 1'b1;
	endtask
	// Pulls the line low for a short spike.
	task automatic glitch(input int w);
		line <= 1'b0;
		repeat (w) @(posedge hclk);
		line <= 1'b1;
	endtask
endmodule

// *** tb_urb_rx.sv ***
// Self-checking bench for the serial receive block.
// Assumes urb_rx is the only bus slave and a model transmitter feeds the line.
`timescale 1ns/1ps
module tb_urb_rx;
	import urb_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, rx_line;
	logic        rx_pin_override, global_irq_enable, rx_complete_irq;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, junk;
	int          fails, check_count, bt;

	// Device under test; the single slave drives hready.
	urb_rx dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.serial_rx_pin(rx_line), .rx_pin_override(rx_pin_override), .global_irq_enable(global_irq_enable),
		.rx_complete_irq(rx_complete_irq));
	urb_tx_model tx (.hclk(hclk), .line(rx_line));

	// Free-running 100 MHz clock.
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Waits, bounded, for hready high at a rising edge.
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			fails++;
			$display("BAD %0t bus hang", $time);
			results();
		end
	endtask
	// One single-word transfer: address phase, then data phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		hsel <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, junk);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		cmp(d & m, e);
	endtask
	// Sends one 8-bit frame and lets it settle into the buffer.
	task automatic frm(input logic [8:0] d, input logic pen, input logic par, input logic stp);
		tx.send(d, 8, bt, pen, par, stp);
		repeat (4) @(posedge hclk);
	endtask

	// Main sequence.
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		global_irq_enable = 1'b0;
		fails = 0;
		check_count = 0;
		bt = 16;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		chk(URB_OFF_CONTROL, 32'hFFFFFFFF, 32'h0);
		chk(URB_OFF_FORMAT, 32'hFFFFFFFF, 32'h3);
		chk(8'h20, 32'hFFFFFFFF, 32'h0);
		chk(URB_OFF_DATA, 32'hFF, 32'h0);
		chk(URB_OFF_STATUS, 32'hFF, 32'h0);
		wr(URB_OFF_CONTROL, 32'h90);
		global_irq_enable <= 1'b1;
		tx.glitch(5);
		repeat (40) @(posedge hclk);
		chk(URB_OFF_STATUS, 32'h80, 32'h0);
		frm(9'h0A5, 1'b0, 1'b0, 1'b1);
		chk(URB_OFF_STATUS, 32'h9C, 32'h80);
		cmp(rx_complete_irq, 1);
		global_irq_enable <= 1'b0;
		repeat (3) @(posedge hclk);
		cmp(rx_complete_irq, 0);
		global_irq_enable <= 1'b1;
		chk(URB_OFF_DATA, 32'hFF, 32'hA5);
		repeat (3) @(posedge hclk);
		cmp(rx_complete_irq, 0);
		wr(URB_OFF_FORMAT, 32'h0B);
		frm(9'h0A5, 1'b0, 1'b0, 1'b0);
		chk(URB_OFF_STATUS, 32'h9C, 32'h90);
		wr(URB_OFF_STATUS, 32'h1C);
		chk(URB_OFF_STATUS, 32'h9C, 32'h90);
		chk(URB_OFF_DATA, 32'hFF, 32'hA5);
		for (int p = 0; p < 2; p++) begin
			for (int b = 0; b < 2; b++) begin
				wr(URB_OFF_FORMAT, {26'h0, 1'b1, p[0], 4'h3});
				frm(9'h03C, 1'b1, (^8'h3C) ^ p[0] ^ b[0], 1'b1);
				chk(URB_OFF_STATUS, 32'h9C, {24'h0, 5'h10, b[0], 2'h0});
				chk(URB_OFF_DATA, 32'hFF, 32'h3C);
			end
		end
		frm(9'h03C, 1'b1, ^8'h3C, 1'b1);
		wr(URB_OFF_FORMAT, 32'h03);
		chk(URB_OFF_STATUS, 32'h84, 32'h80);
		chk(URB_OFF_DATA, 32'hFF, 32'h3C);
		wr(URB_OFF_FORMAT, 32'h13);
		frm(9'h03C, 1'b0, 1'b0, 1'b1);
		wr(URB_OFF_FORMAT, 32'h33);
		chk(URB_OFF_STATUS, 32'h84, 32'h80);
		chk(URB_OFF_DATA, 32'hFF, 32'h3C);
		wr(URB_OFF_FORMAT, 32'h03);
		for (int i = 1; i < 5; i++)
			frm({5'h01, i[3:0]}, 1'b0, 1'b0, 1'b1);
		chk(URB_OFF_STATUS, 32'h88, 32'h80);
		chk(URB_OFF_DATA, 32'hFF, 32'h11);
		chk(URB_OFF_STATUS, 32'h88, 32'h80);
		chk(URB_OFF_DATA, 32'hFF, 32'h12);
		chk(URB_OFF_STATUS, 32'h88, 32'h88);
		chk(URB_OFF_DATA, 32'hFF, 32'h13);
		chk(URB_OFF_STATUS, 32'h88, 32'h0);
		frm(9'h015, 1'b0, 1'b0, 1'b1);
		chk(URB_OFF_STATUS, 32'h88, 32'h80);
		chk(URB_OFF_DATA, 32'hFF, 32'h15);
		frm(9'h021, 1'b0, 1'b0, 1'b1);
		frm(9'h022, 1'b0, 1'b0, 1'b1);
		wr(URB_OFF_CONTROL, 32'h80);
		repeat (3) @(posedge hclk);
		cmp(rx_complete_irq, 0);
		cmp(rx_pin_override, 0);
		chk(URB_OFF_STATUS, 32'h80, 32'h0);
		wr(URB_OFF_CONTROL, 32'h90);
		fork
			tx.send(9'h0FF, 8, bt, 1'b0, 1'b0, 1'b1);
			begin
				repeat (60) @(posedge hclk);
				wr(URB_OFF_CONTROL, 32'h80);
				wr(URB_OFF_CONTROL, 32'h90);
			end
		join
		repeat (40) @(posedge hclk);
		chk(URB_OFF_STATUS, 32'h80, 32'h0);
		wr(URB_OFF_FORMAT, 32'h07);
		tx.send(9'h1C3, 9, bt, 1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge hclk);
		chk(URB_OFF_CONTROL, 32'h02, 32'h02);
		chk(URB_OFF_DATA, 32'hFF, 32'hC3);
		wr(URB_OFF_FORMAT, 32'h00);
		tx.send(9'h015, 5, bt, 1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge hclk);
		chk(URB_OFF_DATA, 32'hFF, 32'h15);
		wr(URB_OFF_FORMAT, 32'h03);
		wr(URB_OFF_STATUS, 32'h02);
		bt = 8;
		frm(9'h05A, 1'b0, 1'b0, 1'b1);
		chk(URB_OFF_DATA, 32'hFF, 32'h5A);
		results();
	end
endmodule
